//--- hdl/dep_cfg.svh
// Constants of the driver enable and protection controller
`ifndef DEP_CFG_SVH
`define DEP_CFG_SVH

// ==========================================================================
// Clock and soft-start timing
`define DEP_CLK_MHZ 20
`define DEP_SOFT_START_US 400
`define DEP_SOFT_START_CYCLES (`DEP_SOFT_START_US * `DEP_CLK_MHZ)
`define DEP_RAMP_W 8

// ==========================================================================
// Board temperature thresholds in degrees C
`define DEP_WARN_ON_C 60
`define DEP_WARN_OFF_C 58
`define DEP_STOP_ON_C 80
`define DEP_STOP_OFF_C 58

// ==========================================================================
// Power-on mode values
`define DEP_RST_EXT_ENABLE 1'b1
`define DEP_RST_EXT_CURRENT 1'b1
`define DEP_RST_INTERLOCK_ALLOW 1'b1
`define DEP_RST_NTC_ALLOW 1'b1

// ==========================================================================
// Input synchroniser depth
`define DEP_SYNC_STAGES 3

`endif

//--- hdl/dep_pkg.sv
// Types of the driver enable and protection controller
package dep_pkg;

    // ======================================================================
    // Output stage states, Gray along off, ramp, on
    typedef enum logic [1:0] {
        DEP_OFF = 2'b00,
        DEP_RAMP = 2'b01,
        DEP_ON = 2'b11,
        DEP_CLAMP = 2'b10
    } dep_state_t;

endpackage

//--- hdl/dep_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "dep_cfg.svh"

module dep_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic [WIDTH-1:0] async_in, // Pin levels
    output logic [WIDTH-1:0] sync_out // Filtered levels
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] out_next;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // Change accepted only once stages two and three agree
            always_comb begin
                out_next[i] = out_reg[i];
                if (s2_reg[i] == s3_reg[i]) begin
                    out_next[i] = s3_reg[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            out_reg <= INIT;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign sync_out = out_reg;
endmodule
`default_nettype wire

//--- hdl/dep_ctrl.sv
// Enable gating, soft-start and protection control of the output stage
`timescale 1ns/1ps
`default_nettype none
`include "dep_cfg.svh"

// Functional notes
// R1 - Output current flows only while enable is high; low stops it.
// R2 - Every enable rising edge starts a gradual soft-start ramp.
// R3 - A square wave on enable switches the output pulse by pulse.
// R4 - Overcurrent or over-temperature shutdown holds the crowbar clamp on.
// R5 - During shutdown the enable input is ignored and output stays off.
// R6 - Protection fault stays latched until power-on reset only.
// R7 - Crowbar status output is high while a fault is latched.
// R8 - Interlock must be low to run; open interlock locks output off.
// R9 - Warning sets above 60 C, clears below 58 C.
// R10 - Stop above 80 C; restart allowed once back at 58 C.
// R11 - Thermistor outside the set window blocks; inside again resumes.
// R12 - Thermistor temperature is readable on the control side.
// R13 - Power-on mode: analogue current, external enable, interlock allowed.
// R14 - Enable, interlock and overcurrent inputs are synchronised first.
module dep_ctrl #(
    parameter int TW = 10,
    parameter int SOFT_START_CYCLES = `DEP_SOFT_START_CYCLES
) (
    input wire logic clk, // 20 MHz clock
    input wire logic reset, // Power-on reset
    input wire logic enable_pin, // Enable, high runs
    input wire logic interlock_pin, // Interlock, low runs
    input wire logic overcurrent_pin, // Overcurrent comparator
    input wire logic signed [TW-1:0] board_temp, // Board temperature, C
    input wire logic signed [TW-1:0] ntc_temp, // Thermistor temperature, C
    input wire logic signed [TW-1:0] ntc_upper, // Thermistor upper limit
    input wire logic signed [TW-1:0] ntc_lower, // Thermistor lower limit
    input wire logic mode_write, // Mode update strobe
    input wire logic mode_ext_enable, // 1 enable pin, 0 internal
    input wire logic mode_ext_current, // 1 analogue current set
    input wire logic mode_interlock_allow, // 1 interlock checked
    input wire logic mode_ntc_allow, // 1 thermistor window checked
    input wire logic internal_enable, // Enable in internal mode
    output logic output_on, // Output stage running
    output logic [`DEP_RAMP_W-1:0] ramp_level, // Current ramp scale
    output logic crowbar_on, // Crowbar clamp drive
    output logic crowbar_status, // Latched fault status
    output logic temp_warning, // Over-temperature warning
    output logic thermal_stop, // Over-temperature shutdown
    output logic ntc_blocked, // Thermistor window block
    output logic [TW-1:0] ntc_readback, // Thermistor value for readout
    output logic ext_current_sel, // Analogue current set in use
    output logic ext_enable_sel, // Enable pin in use
    output logic interlock_sel // Interlock checked
);
    localparam int STEP_CYCLES =
        (SOFT_START_CYCLES + (1 << `DEP_RAMP_W) - 2) /
        ((1 << `DEP_RAMP_W) - 1);
    localparam int SW = $clog2(STEP_CYCLES + 1);
    localparam logic [`DEP_RAMP_W-1:0] RAMP_MAX = '1;

    // ======================================================================
    // Input synchronisation
    logic [2:0] pins_sync;
    logic en_s;
    logic lock_s;
    logic oc_s;

    dep_sync #(.WIDTH(3), .INIT(3'h2)) u_sync ( // see R14
        .clk(clk),
        .reset(reset),
        .async_in({overcurrent_pin, interlock_pin, enable_pin}),
        .sync_out(pins_sync)
    );
    assign en_s = pins_sync[0];
    assign lock_s = pins_sync[1];
    assign oc_s = pins_sync[2];

    // ======================================================================
    // Mode bits
    logic ext_en_reg, ext_en_next;
    logic ext_cur_reg, ext_cur_next;
    logic ilk_reg, ilk_next;
    logic ntc_allow_reg, ntc_allow_next;

    always_comb begin
        ext_en_next = ext_en_reg;
        ext_cur_next = ext_cur_reg;
        ilk_next = ilk_reg;
        ntc_allow_next = ntc_allow_reg;
        if (mode_write) begin
            ext_en_next = mode_ext_enable;
            ext_cur_next = mode_ext_current;
            ilk_next = mode_interlock_allow;
            ntc_allow_next = mode_ntc_allow;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ext_en_reg <= `DEP_RST_EXT_ENABLE; // see R13
            ext_cur_reg <= `DEP_RST_EXT_CURRENT; // see R13
            ilk_reg <= `DEP_RST_INTERLOCK_ALLOW; // see R13
            ntc_allow_reg <= `DEP_RST_NTC_ALLOW;
        end else begin
            ext_en_reg <= ext_en_next;
            ext_cur_reg <= ext_cur_next;
            ilk_reg <= ilk_next;
            ntc_allow_reg <= ntc_allow_next;
        end
    end

    // ======================================================================
    // Protection and temperature supervision
    logic oc_fault_reg, oc_fault_next;
    logic warn_reg, warn_next;
    logic tstop_reg, tstop_next;
    logic ntc_blk_reg, ntc_blk_next;
    logic [TW-1:0] ntc_rd_reg;
    logic shutdown;

    always_comb begin
        // Sticky until power-on reset, no input clears it
        oc_fault_next = oc_fault_reg | oc_s; // see R6
        warn_next = warn_reg;
        if (board_temp > `DEP_WARN_ON_C) begin
            warn_next = 1'b1; // see R9
        end else if (board_temp < `DEP_WARN_OFF_C) begin
            warn_next = 1'b0; // see R9
        end
        tstop_next = tstop_reg;
        if (board_temp > `DEP_STOP_ON_C) begin
            tstop_next = 1'b1; // see R10
        end else if (board_temp <= `DEP_STOP_OFF_C) begin
            tstop_next = 1'b0; // see R10
        end
        ntc_blk_next = ntc_allow_reg &&
            (ntc_temp > ntc_upper || ntc_temp < ntc_lower); // see R11
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            oc_fault_reg <= 1'b0;
            warn_reg <= 1'b0;
            tstop_reg <= 1'b0;
            ntc_blk_reg <= 1'b0;
            ntc_rd_reg <= '0;
        end else begin
            oc_fault_reg <= oc_fault_next;
            warn_reg <= warn_next;
            tstop_reg <= tstop_next;
            ntc_blk_reg <= ntc_blk_next;
            ntc_rd_reg <= ntc_temp; // see R12
        end
    end

    assign shutdown = oc_fault_reg | tstop_reg;

    // ======================================================================
    // Output stage control
    dep_pkg::dep_state_t st_reg, st_next;
    logic [`DEP_RAMP_W-1:0] lvl_reg, lvl_next;
    logic [SW-1:0] step_reg, step_next;
    logic crow_reg, crow_next;
    logic run_req;

    // Interlock ignored only when software denied it
    assign run_req = (ext_en_reg ? en_s : internal_enable) // see R1
        && !(ilk_reg && lock_s) // see R8
        && !ntc_blk_reg; // see R11

    always_comb begin
        st_next = st_reg;
        lvl_next = lvl_reg;
        step_next = step_reg;
        crow_next = shutdown; // see R4
        case (st_reg)
            dep_pkg::DEP_OFF: begin
                lvl_next = '0;
                step_next = '0;
                if (run_req) begin
                    st_next = dep_pkg::DEP_RAMP; // see R2
                end
            end
            dep_pkg::DEP_RAMP: begin
                if (step_reg == SW'(STEP_CYCLES - 1)) begin
                    step_next = '0;
                    lvl_next = lvl_reg + 1'b1; // see R2
                    if (lvl_reg == RAMP_MAX - 1'b1) begin
                        st_next = dep_pkg::DEP_ON;
                    end
                end else begin
                    step_next = step_reg + 1'b1;
                end
            end
            dep_pkg::DEP_ON: begin
                lvl_next = RAMP_MAX;
            end
            dep_pkg::DEP_CLAMP: begin
                lvl_next = '0;
                step_next = '0;
                if (!shutdown) begin
                    st_next = dep_pkg::DEP_OFF; // see R10
                end
            end
            default: begin
                st_next = dep_pkg::DEP_OFF;
            end
        endcase
        // Pulse-by-pulse follow of the enable level
        if (st_reg != dep_pkg::DEP_CLAMP && !run_req) begin
            st_next = dep_pkg::DEP_OFF; // see R3
            lvl_next = '0;
        end
        // Shutdown overrides every request
        if (shutdown) begin
            st_next = dep_pkg::DEP_CLAMP; // see R5
            lvl_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= dep_pkg::DEP_OFF;
            lvl_reg <= '0;
            step_reg <= '0;
            crow_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            lvl_reg <= lvl_next;
            step_reg <= step_next;
            crow_reg <= crow_next;
        end
    end

    // Gray code puts both run states on bit 0, so no decode gate here
    assign output_on = st_reg[0];
    assign ramp_level = lvl_reg;
    assign crowbar_on = crow_reg;
    assign crowbar_status = crow_reg; // see R7
    assign temp_warning = warn_reg;
    assign thermal_stop = tstop_reg;
    assign ntc_blocked = ntc_blk_reg;
    assign ntc_readback = ntc_rd_reg;
    assign ext_current_sel = ext_cur_reg;
    assign ext_enable_sel = ext_en_reg;
    assign interlock_sel = ilk_reg;

    // ======================================================================
    // Checks
    off_when_low_a: assert property (@(posedge clk) disable iff (reset)
        !run_req |=> !output_on) // see R1
        else $error("output on without run request");
    start_ramps_a: assert property (@(posedge clk) disable iff (reset)
        st_reg == dep_pkg::DEP_OFF && run_req && !shutdown
        |=> st_reg == dep_pkg::DEP_RAMP && lvl_reg == '0) // see R2
        else $error("start did not enter ramp at zero");
    ramp_monotone_a: assert property (@(posedge clk) disable iff (reset)
        st_reg == dep_pkg::DEP_RAMP && $past(st_reg) == dep_pkg::DEP_RAMP
        |-> lvl_reg >= $past(lvl_reg)) // see R2
        else $error("ramp level fell during ramp");
    clamp_shutdown_a: assert property (@(posedge clk) disable iff (reset)
        shutdown |=> crowbar_on && !output_on) // see R4
        else $error("shutdown without clamp");
    enable_ignored_a: assert property (@(posedge clk) disable iff (reset)
        oc_fault_reg |-> ##1 (!output_on)[*8]) // see R5
        else $error("output restarted during fault");
    fault_sticky_a: assert property (@(posedge clk) disable iff (reset)
        oc_fault_reg |=> oc_fault_reg && crowbar_status) // see R6
        else $error("latched fault cleared");
    status_level_a: assert property (@(posedge clk) disable iff (reset)
        !shutdown && !$past(shutdown) |-> !crowbar_status) // see R7
        else $error("crowbar status high in normal run");
    interlock_lock_a: assert property (@(posedge clk) disable iff (reset)
        ilk_reg && lock_s |=> !output_on) // see R8
        else $error("output on with open interlock");
    warn_hyst_a: assert property (@(posedge clk) disable iff (reset)
        warn_reg && board_temp >= `DEP_WARN_OFF_C |=> warn_reg) // see R9
        else $error("warning cleared inside hysteresis");
    stop_temp_a: assert property (@(posedge clk) disable iff (reset)
        board_temp > `DEP_STOP_ON_C |=> tstop_reg ##1 !output_on) // see R10
        else $error("no stop above limit");
    ntc_window_a: assert property (@(posedge clk) disable iff (reset)
        ntc_allow_reg && ntc_temp > ntc_upper |=> ##1 !output_on) // see R11
        else $error("thermistor window not enforced");

    pulse_cycle_c: cover property (@(posedge clk) disable iff (reset)
        output_on ##1 !output_on ##[1:20] output_on);
    ramp_done_c: cover property (@(posedge clk) disable iff (reset)
        st_reg == dep_pkg::DEP_RAMP ##1 st_reg == dep_pkg::DEP_ON);
    oc_trip_c: cover property (@(posedge clk) disable iff (reset)
        output_on ##1 crowbar_on);
    thermal_recover_c: cover property (@(posedge clk) disable iff (reset)
        tstop_reg ##1 !tstop_reg);
endmodule
`default_nettype wire

//--- test/dep_ctl_model.sv
// Behavioural external controller driving enable and interlock
`timescale 1ns/1ps
`default_nettype none

module dep_ctl_model #(
    parameter int HALF = 20
) (
    input wire logic clk, // System clock
    input wire logic run, // Steady run request
    input wire logic pulse, // Square wave on enable
    input wire logic lock_open, // Interlock contact open
    output logic enable_pin, // Enable to the driver
    output logic interlock_pin // Interlock to the driver
);
    // ======================================================================
    // Square wave generator, low for the first half period
    int cnt = 0;
    logic sq = 1'b0;

    always @(posedge clk) begin
        if (!pulse) begin
            cnt <= 0;
            sq <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            sq <= !sq;
        end else begin
            cnt <= cnt + 1;
        end
    end

    assign enable_pin = pulse ? sq : run;
    // Open contact reads high through the pull-up
    assign interlock_pin = lock_open ? 1'b1 : 1'b0;
endmodule
`default_nettype wire

//--- test/test_driver_enable_protection_ctrl.sv
// Self-checking bench of the driver enable and protection controller
`timescale 1ns/1ps
`default_nettype none

module test_driver_enable_protection_ctrl;
    localparam int TW = 10;
    localparam int SS = 255;
    localparam int LIMIT = 6000;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic run = 1'b0;
    logic pulse = 1'b0;
    logic lock_open = 1'b0;
    logic enable_pin, interlock_pin, oc = 1'b0;
    logic signed [TW-1:0] board_temp = 10'sd25;
    logic signed [TW-1:0] ntc_temp = 10'sd25;
    logic signed [TW-1:0] ntc_upper = 10'sd100;
    logic signed [TW-1:0] ntc_lower = 10'sd0;
    logic mode_write = 1'b0;
    logic ext_en = 1'b1;
    logic int_en = 1'b0;
    logic cur_ext = 1'b1;
    logic ilk_allow = 1'b1;
    logic ntc_allow = 1'b1;
    logic output_on, crowbar_on, crowbar_status, temp_warning;
    logic thermal_stop, ntc_blocked, cur_sel, en_sel, lock_sel;
    logic [7:0] ramp_level;
    logic [TW-1:0] ntc_readback;
    logic on_q = 1'b0;
    int checks = 0;
    int error_cnt = 0;
    int rises = 0;
    int cycles = 0;
    int wt[4] = '{61, 59, 57, 60};
    int nt[4] = '{101, 100, -1, 0};

    always #25 clk = !clk;

    dep_ctl_model #(.HALF(20)) u_ctl (.clk(clk), .run(run), .pulse(pulse),
        .lock_open(lock_open), .enable_pin(enable_pin),
        .interlock_pin(interlock_pin));

    dep_ctrl #(.TW(TW), .SOFT_START_CYCLES(SS)) u_dut (.clk(clk),
        .reset(reset), .enable_pin(enable_pin),
        .interlock_pin(interlock_pin), .overcurrent_pin(oc),
        .board_temp(board_temp), .ntc_temp(ntc_temp),
        .ntc_upper(ntc_upper), .ntc_lower(ntc_lower),
        .mode_write(mode_write), .mode_ext_enable(ext_en),
        .mode_ext_current(cur_ext), .mode_interlock_allow(ilk_allow),
        .mode_ntc_allow(ntc_allow), .internal_enable(int_en),
        .output_on(output_on), .ramp_level(ramp_level),
        .crowbar_on(crowbar_on), .crowbar_status(crowbar_status),
        .temp_warning(temp_warning), .thermal_stop(thermal_stop),
        .ntc_blocked(ntc_blocked), .ntc_readback(ntc_readback),
        .ext_current_sel(cur_sel), .ext_enable_sel(en_sel),
        .interlock_sel(lock_sel));

    // ======================================================================
    // Helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic wait_on(input logic v, input int n);
        int i;
        i = 0;
        while (output_on !== v && i < n) begin
            step(1);
            i++;
        end
        chk(16'(output_on), 16'(v));
    endtask

    task automatic wrap_up;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Settled values only, sampled away from the launching edge
    always @(negedge clk) begin
        if (output_on === 1'b1 && on_q === 1'b0) begin
            rises++;
            chk(16'(ramp_level), 16'h0);
        end
        on_q <= output_on;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ======================================================================
    // Test sequence
    initial begin
        step(4);
        reset = 1'b0;
        step(1);
        chk(16'({output_on, crowbar_on, crowbar_status}), 16'h0);
        chk(16'({cur_sel, en_sel, lock_sel}), 16'h7);
        run = 1'b1;
        wait_on(1'b1, 8);
        step(SS + 20);
        chk(16'(ramp_level), 16'h00ff);
        run = 1'b0;
        wait_on(1'b0, 8);
        lock_open = 1'b1;
        run = 1'b1;
        step(20);
        chk(16'(output_on), 16'h0);
        lock_open = 1'b0;
        wait_on(1'b1, 8);
        run = 1'b0;
        step(10);
        rises = 0;
        pulse = 1'b1;
        step(200);
        pulse = 1'b0;
        step(10);
        chk(16'(rises), 16'h5);
        chk(16'(output_on), 16'h0);
        for (int i = 0; i < 4; i++) begin
            board_temp = TW'(wt[i]);
            step(3);
            chk(16'(temp_warning), 16'(i < 2));
        end
        run = 1'b1;
        wait_on(1'b1, 8);
        board_temp = 10'sd81;
        step(3);
        chk(16'({thermal_stop, crowbar_on}), 16'h3);
        chk(16'({crowbar_status, output_on}), 16'h2);
        run = 1'b0;
        step(6);
        run = 1'b1;
        step(10);
        chk(16'(output_on), 16'h0);
        board_temp = 10'sd59;
        step(3);
        chk(16'(thermal_stop), 16'h1);
        board_temp = 10'sd58;
        step(3);
        chk(16'({thermal_stop, crowbar_on}), 16'h0);
        wait_on(1'b1, 8);
        board_temp = 10'sd25;
        for (int i = 0; i < 4; i++) begin
            ntc_temp = TW'(nt[i]);
            step(4);
            chk(16'({ntc_blocked, output_on}), 16'(i[0] ? 1 : 2));
            chk(16'(ntc_readback), 16'(TW'(unsigned'(nt[i]))));
        end
        // Internal enable path, pin still high but no longer in charge
        ext_en = 1'b0;
        mode_write = 1'b1;
        step(1);
        mode_write = 1'b0;
        wait_on(1'b0, 8);
        chk(16'(en_sel), 16'h0);
        int_en = 1'b1;
        wait_on(1'b1, 8);
        // Interlock and thermistor checks switched off by mode
        {ilk_allow, ntc_allow, cur_ext} = 3'b000;
        mode_write = 1'b1;
        step(1);
        mode_write = 1'b0;
        lock_open = 1'b1;
        ntc_temp = 10'sd101;
        step(8);
        chk(16'({ntc_blocked, output_on}), 16'h1);
        chk(16'({output_on, lock_sel, cur_sel}), 16'h4);
        {ilk_allow, ntc_allow, cur_ext} = 3'b111;
        lock_open = 1'b0;
        ntc_temp = 10'sd25;
        oc = 1'b1;
        step(8);
        oc = 1'b0;
        chk(16'({crowbar_on, crowbar_status, output_on}), 16'h6);
        ext_en = 1'b1;
        mode_write = 1'b1;
        step(1);
        mode_write = 1'b0;
        run = 1'b0;
        step(6);
        run = 1'b1;
        step(20);
        chk(16'({crowbar_status, output_on}), 16'h2);
        reset = 1'b1;
        step(4);
        reset = 1'b0;
        run = 1'b0;
        step(1);
        chk(16'({crowbar_status, crowbar_on}), 16'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
